// ==== core/sccsd_io_chan.sv ====
// one programmable i/o chip select window
`timescale 1ns/100ps
module sccsd_io_chan (
  // configuration
  input  wire logic [15:0] base,
  input  wire logic [7:0]  ctrl,
  // bus cycle
  input  wire logic        cyc_valid,
  input  wire logic        cyc_io,
  input  wire logic        cyc_write,
  input  wire logic [15:0] cyc_addr,
  // result
  output logic             hit
);
  // ==========================================================
  // range code to window size
  logic [5:0]  size;
  logic        code_ok;
  logic [16:0] diff;
  logic        dir_ok;

  always_comb begin
    code_ok = 1'b1;
    case (ctrl[4:0])
      5'h00:   size = 6'h01;
      5'h01:   size = 6'h02;
      5'h03:   size = 6'h04;
      5'h07:   size = 6'h08;
      5'h0f:   size = 6'h10;
      5'h1f:   size = 6'h20;
      default: begin
        // reserved codes decode nothing rather than guess a size
        size    = 6'h00;
        code_ok = 1'b0;
      end
    endcase
  end

  // 17-bit difference: borrow means below base, no wrap past ffff
  assign diff   = {1'b0, cyc_addr} - {1'b0, base};
  assign dir_ok = (cyc_write & ctrl[sccsd_pkg::IO_WR_BIT])
                | (!cyc_write & ctrl[sccsd_pkg::IO_RD_BIT]);
  assign hit    = cyc_valid & cyc_io & ctrl[sccsd_pkg::IO_EN_BIT]
                & dir_ok & code_ok & !diff[16]
                & (diff[15:0] < {10'h000, size});
endmodule

// ==== core/sccsd_pkg.sv ====
// constants for the sub-isa chip select decoder
package sccsd_pkg;
  // ==========================================================
  // register indices and byte addresses (byte address = 4 x index)
  localparam int unsigned        AW           = 12;
  localparam logic [7:0]         IDX_ROM_MASK = 8'h6e;
  localparam logic [7:0]         IDX_B_BASE   = 8'h70;
  localparam logic [7:0]         IDX_B_CTRL   = 8'h72;
  localparam logic [7:0]         IDX_A_BASE   = 8'h74;
  localparam logic [7:0]         IDX_A_CTRL   = 8'h76;
  localparam logic [7:0]         IDX_FD_BASE  = 8'h78;
  localparam logic [7:0]         IDX_FD_CTRL  = 8'h7c;
  localparam logic [7:0]         IDX_STATUS   = 8'h80;
  // ==========================================================
  // field positions
  localparam int unsigned        IO_EN_BIT    = 7;
  localparam int unsigned        IO_WR_BIT    = 6;
  localparam int unsigned        IO_RD_BIT    = 5;
  localparam int unsigned        FD_EN_BIT    = 26;
  localparam int unsigned        FD_WR_BIT    = 25;
  localparam int unsigned        FD_RD_BIT    = 24;
  localparam int unsigned        FD_MASK_W    = 19;
  localparam int unsigned        FD_ADDR_LSB  = 13;
  // ==========================================================
  // reset values and fixed bits
  localparam logic [15:0]        ROM_MASK_RST = 16'hfff0;
  localparam logic [3:0]         ROM_SIZE_RST = 4'hf;
  localparam logic [7:0]         ROM_HI_FIXED = 8'hff;
  localparam logic [7:0]         ROM_TOP_BYTE = 8'hff;
  localparam logic [15:0]        IO_BASE_RST  = 16'h0000;
  localparam logic [7:0]         IO_CTRL_RST  = 8'h00;
  localparam logic [31:0]        FD_BASE_RST  = 32'h00000000;
  localparam logic [31:0]        FD_CTRL_RST  = 32'h00000000;
  localparam logic [31:0]        FD_CTRL_MASK = 32'h0707ffff;
endpackage

// ==== core/sccsd_top.sv ====
// sub-isa chip select decoder with apb register access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module sccsd_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // decoded bus cycle
  input  wire logic        cyc_valid,
  input  wire logic        cyc_io,
  input  wire logic        cyc_write,
  input  wire logic [31:0] cyc_addr,
  input  wire logic        rom_decode_en,
  // chip selects
  output logic             io_select_a_n,
  output logic             io_select_b_n,
  output logic             flash_disk_select_n,
  output logic             boot_rom_select_n
);
  // ==========================================================
  // apb decode
  logic        setup;
  logic        access;
  logic [7:0]  idx;
  logic        mapped;
  logic [31:0] rd_val;

  assign setup  = psel & !penable;
  assign access = psel & penable;
  assign idx    = paddr[9:2];
  // registers answer in the first access cycle, no wait states
  assign pready = 1'b1;

  always_comb begin
    mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    case (idx)
      sccsd_pkg::IDX_ROM_MASK, sccsd_pkg::IDX_B_BASE, sccsd_pkg::IDX_B_CTRL,
      sccsd_pkg::IDX_A_BASE, sccsd_pkg::IDX_A_CTRL, sccsd_pkg::IDX_FD_BASE,
      sccsd_pkg::IDX_FD_CTRL, sccsd_pkg::IDX_STATUS: ;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = access & !mapped;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // configuration registers
  logic [15:0] io_base_r [2];
  logic [15:0] io_base_nxt [2];
  logic [7:0]  io_ctrl_r [2];
  logic [7:0]  io_ctrl_nxt [2];
  logic [31:0] fd_base_r;
  logic [31:0] fd_base_nxt;
  logic [31:0] fd_ctrl_r;
  logic [31:0] fd_ctrl_nxt;
  logic [3:0]  rom_size_r;
  logic [3:0]  rom_size_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        wr_ok;
  logic [31:0] tmp;

  assign wr_ok = access & pwrite & mapped;

  always_comb begin
    io_base_nxt  = io_base_r;
    io_ctrl_nxt  = io_ctrl_r;
    fd_base_nxt  = fd_base_r;
    fd_ctrl_nxt  = fd_ctrl_r;
    rom_size_nxt = rom_size_r;
    tmp          = 32'h00000000;
    if (wr_ok) begin
      case (idx)
        sccsd_pkg::IDX_ROM_MASK: begin
          // only the size field is storage; 15:8 and 3:0 are fixed
          tmp          = wmerge({16'h0000, 8'h00, rom_size_r, 4'h0}, pwdata, pstrb);
          rom_size_nxt = tmp[7:4];
        end
        sccsd_pkg::IDX_B_BASE: begin
          tmp            = wmerge({16'h0000, io_base_r[1]}, pwdata, pstrb);
          io_base_nxt[1] = tmp[15:0];
        end
        sccsd_pkg::IDX_B_CTRL: begin
          tmp            = wmerge({24'h000000, io_ctrl_r[1]}, pwdata, pstrb);
          io_ctrl_nxt[1] = tmp[7:0];
        end
        sccsd_pkg::IDX_A_BASE: begin
          tmp            = wmerge({16'h0000, io_base_r[0]}, pwdata, pstrb);
          io_base_nxt[0] = tmp[15:0];
        end
        sccsd_pkg::IDX_A_CTRL: begin
          tmp            = wmerge({24'h000000, io_ctrl_r[0]}, pwdata, pstrb);
          io_ctrl_nxt[0] = tmp[7:0];
        end
        sccsd_pkg::IDX_FD_BASE: begin
          fd_base_nxt = wmerge(fd_base_r, pwdata, pstrb);
        end
        sccsd_pkg::IDX_FD_CTRL: begin
          // reserved bits never store, so they read back as zero
          fd_ctrl_nxt = wmerge(fd_ctrl_r, pwdata, pstrb) & sccsd_pkg::FD_CTRL_MASK;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read data, captured in the setup phase
  logic [3:0]  sel_live;

  always_comb begin
    case (idx)
      sccsd_pkg::IDX_ROM_MASK: rd_val = {16'h0000, sccsd_pkg::ROM_HI_FIXED,
                                         rom_size_r, 4'h0};
      sccsd_pkg::IDX_B_BASE:   rd_val = {16'h0000, io_base_r[1]};
      sccsd_pkg::IDX_B_CTRL:   rd_val = {24'h000000, io_ctrl_r[1]};
      sccsd_pkg::IDX_A_BASE:   rd_val = {16'h0000, io_base_r[0]};
      sccsd_pkg::IDX_A_CTRL:   rd_val = {24'h000000, io_ctrl_r[0]};
      sccsd_pkg::IDX_FD_BASE:  rd_val = fd_base_r;
      sccsd_pkg::IDX_FD_CTRL:  rd_val = fd_ctrl_r;
      sccsd_pkg::IDX_STATUS:   rd_val = {28'h0000000, sel_live};
      default:                 rd_val = 32'h00000000;
    endcase
    if (!mapped) begin
      rd_val = 32'h00000000;
    end
    prdata_nxt = (setup && !pwrite) ? rd_val : prdata_r;
  end

  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        io_base_r[i] <= sccsd_pkg::IO_BASE_RST;
        io_ctrl_r[i] <= sccsd_pkg::IO_CTRL_RST;
      end
      fd_base_r  <= sccsd_pkg::FD_BASE_RST;
      fd_ctrl_r  <= sccsd_pkg::FD_CTRL_RST;
      rom_size_r <= sccsd_pkg::ROM_SIZE_RST;
      prdata_r   <= 32'h00000000;
    end else begin
      io_base_r  <= io_base_nxt;
      io_ctrl_r  <= io_ctrl_nxt;
      fd_base_r  <= fd_base_nxt;
      fd_ctrl_r  <= fd_ctrl_nxt;
      rom_size_r <= rom_size_nxt;
      prdata_r   <= prdata_nxt;
    end
  end

  // ==========================================================
  // address decode
  logic [1:0]  io_hit;
  logic        fd_hit;
  logic        fd_dir;
  logic [18:0] fd_mask;
  logic        rom_hit;
  logic        rom_code_ok;

  for (genvar g = 0; g < 2; g++) begin : g_io
    sccsd_io_chan u_chan (
      .base      (io_base_r[g]),
      .ctrl      (io_ctrl_r[g]),
      .cyc_valid (cyc_valid),
      .cyc_io    (cyc_io),
      .cyc_write (cyc_write),
      .cyc_addr  (cyc_addr[15:0]),
      .hit       (io_hit[g])
    );
  end

  assign fd_mask = fd_ctrl_r[sccsd_pkg::FD_MASK_W-1:0];
  assign fd_dir  = (cyc_write & fd_ctrl_r[sccsd_pkg::FD_WR_BIT])
                 | (!cyc_write & fd_ctrl_r[sccsd_pkg::FD_RD_BIT]);
  assign fd_hit  = cyc_valid & !cyc_io & fd_ctrl_r[sccsd_pkg::FD_EN_BIT] & fd_dir
                 & (((cyc_addr[31:sccsd_pkg::FD_ADDR_LSB]
                    ^ fd_base_r[31:sccsd_pkg::FD_ADDR_LSB]) & fd_mask) == 19'h00000);

  // a one bit in the size code forces the matching address bit high
  always_comb begin
    case (rom_size_r)
      4'h0, 4'h8, 4'hc, 4'he, 4'hf: rom_code_ok = 1'b1;
      default:                      rom_code_ok = 1'b0;
    endcase
  end

  assign rom_hit = cyc_valid & !cyc_io & rom_decode_en & rom_code_ok
                 & (cyc_addr[31:24] == sccsd_pkg::ROM_TOP_BYTE)
                 & ((cyc_addr[23:20] & rom_size_r) == rom_size_r);

  // ==========================================================
  // registered selects, one clock behind the decode, released one clock after the hitting cycle ends
  logic [3:0] sel_r;
  logic [3:0] sel_nxt;

  always_comb begin
    sel_nxt = {rom_hit, fd_hit, io_hit};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 4'h0;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  assign sel_live            = sel_r;
  assign io_select_a_n       = !sel_r[0];
  assign io_select_b_n       = !sel_r[1];
  assign flash_disk_select_n = !sel_r[2];
  assign boot_rom_select_n   = !sel_r[3];

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic io_a_rd;
  assign io_a_rd = cyc_valid & cyc_io & !cyc_write;

  a_io_disabled_quiet: assert property (
    !io_ctrl_r[0][7] |=> io_select_a_n)
    else $error("select a asserted while decode disabled");
  a_io_write_hit: assert property (
    (io_ctrl_r[0][7:6] == 2'b11) && (io_ctrl_r[0][4:0] == 5'h03) && cyc_valid
    && cyc_io && cyc_write && (cyc_addr[15:0] == io_base_r[0] + 16'h0003)
    && (io_base_r[0] < 16'hfffc) |=> !io_select_a_n)
    else $error("write inside window missed");
  a_io_read_off: assert property (
    io_a_rd && !io_ctrl_r[0][5] |=> io_select_a_n)
    else $error("read asserted select with reads disabled");
  a_io_range_edge: assert property (
    io_a_rd && (io_ctrl_r[0][4:0] == 5'h07) && (io_base_r[0] < 16'hfff0)
    && (cyc_addr[15:0] == io_base_r[0] + 16'h0008) |=> io_select_a_n)
    else $error("select beyond eight byte window");
  a_io_b_read: assert property (
    cyc_valid && cyc_io && !cyc_write && (io_ctrl_r[1] == 8'ha0)
    && (cyc_addr[15:0] == io_base_r[1]) |=> !io_select_b_n)
    else $error("channel b one byte read missed");
  a_flash_off: assert property (
    !fd_ctrl_r[26] |=> flash_disk_select_n)
    else $error("flash select while disabled");
  a_flash_write: assert property (
    cyc_valid && !cyc_io && cyc_write && fd_ctrl_r[26] && fd_ctrl_r[25]
    && (cyc_addr == fd_base_r) |=> !flash_disk_select_n)
    else $error("flash write at base missed");
  a_flash_read_off: assert property (
    cyc_valid && !cyc_write && !fd_ctrl_r[24] |=> flash_disk_select_n)
    else $error("flash read with reads disabled");
  a_flash_mask_miss: assert property (
    (fd_ctrl_r[18:0] == 19'h7ffff)
    && (cyc_addr[31:13] != fd_base_r[31:13]) |=> flash_disk_select_n)
    else $error("flash select outside full mask");
  a_rom_window: assert property (
    cyc_valid && !cyc_io && rom_decode_en && (rom_size_r == 4'hc)
    && (cyc_addr[31:22] == 10'h3ff) |=> !boot_rom_select_n ##1 1'b1)
    else $error("rom 4 MB window missed");
  a_idle_release: assert property (
    !cyc_valid [*2] |-> io_select_a_n && io_select_b_n
                     && flash_disk_select_n && boot_rom_select_n)
    else $error("select held after cycle ended");
  a_rom_fixed_bits: assert property (
    setup && !pwrite && (paddr == 12'h1b8) |=> prdata[15:8] == 8'hff
    && prdata[3:0] == 4'h0)
    else $error("rom mask fixed bits wrong");

  c_io_a_hit:  cover property (!io_select_a_n);
  c_io_b_hit:  cover property (!io_select_b_n);
  c_flash_hit: cover property (!flash_disk_select_n);
  c_rom_hit:   cover property (!boot_rom_select_n);
endmodule

// ==== tb/sccsd_periph_model.sv ====
// far-side peripheral model that counts strobed cycles on select a
`timescale 1ns/100ps
module sccsd_periph_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // select line from the decoder
  input  wire logic       io_select_a_n,
  // observation
  output logic [7:0]      a_sel_cnt
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  // ==========================================
  // count every clock the select is low; a stuck select inflates it
  always_comb begin
    cnt_nxt = cnt_r;
    if (io_select_a_n === 1'b0) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign a_sel_cnt = cnt_r;
endmodule

// ==== tb/tb_subisa_chip_select_decoder.sv ====
// self-checking bench for the sub-isa chip select decoder
`timescale 1ns/100ps
module tb_subisa_chip_select_decoder;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdat, cyc_addr = 32'h00000000;
  logic        pready, pslverr, rerr, cyc_valid = 1'b0, cyc_io = 1'b0, cyc_write = 1'b0;
  logic        rom_decode_en = 1'b0, sa_n, sb_n, sf_n, sr_n;
  logic [7:0]  a_cnt;
  int          errors = 0, checks = 0;
  localparam logic [3:0] NONE = 4'hf, SA = 4'he, SB = 4'hd, SF = 4'hb, SR = 4'h7;
  always #2.5 pclk = ~pclk;
  sccsd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_io(cyc_io),
    .cyc_write(cyc_write), .cyc_addr(cyc_addr), .rom_decode_en(rom_decode_en),
    .io_select_a_n(sa_n), .io_select_b_n(sb_n), .flash_disk_select_n(sf_n),
    .boot_rom_select_n(sr_n));
  sccsd_periph_model periph_u (.pclk(pclk), .presetn(presetn), .io_select_a_n(sa_n),
    .a_sel_cnt(a_cnt));
  // ==========================================
  // shared tasks
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer held until pready is seen high with penable; only the watchdog ends a hang
  task automatic rw(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-clock bus cycle; selects judged one clock later, then released
  task automatic bus(input logic io, input logic w, input logic [31:0] a, input logic [3:0] e);
    @(posedge pclk);
    cyc_valid <= 1'b1;
    cyc_io <= io;
    cyc_write <= w;
    cyc_addr <= a;
    @(posedge pclk);
    cyc_valid <= 1'b0;
    #1;
    chk({28'h0, sr_n, sf_n, sb_n, sa_n}, {28'h0, e});
    @(posedge pclk);
    #1;
    chk({28'h0, sr_n, sf_n, sb_n, sa_n}, {28'h0, NONE});
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [7:0] ix [6] = '{8'h70, 8'h72, 8'h74, 8'h76, 8'h78, 8'h7c};
    rw(1'b0, sccsd_pkg::IDX_ROM_MASK, 32'h0);
    chk(rdat, 32'h0000fff0);
    foreach (ix[i]) begin
      rw(1'b0, ix[i], 32'h0);
      chk(rdat, 32'h0);
    end
    rw(1'b0, 8'h81, 32'h0);
    chk({31'h0, rerr}, 32'h1);
  endtask
  task automatic t_rom();
    logic [3:0] code [5] = '{4'h0, 4'h8, 4'hc, 4'he, 4'hf};
    rom_decode_en <= 1'b1;
    foreach (code[i]) begin
      rw(1'b1, sccsd_pkg::IDX_ROM_MASK, {16'h0, 8'hff, code[i], 4'h0});
      rw(1'b0, sccsd_pkg::IDX_ROM_MASK, 32'h0);
      chk(rdat, {16'h0, 8'hff, code[i], 4'h0});
      bus(1'b0, 1'b0, {8'hff, code[i], 20'h0}, SR);
      bus(1'b0, 1'b1, 32'hffffffff, SR);
      bus(1'b0, 1'b0, {8'hff, code[i], 20'h0} - 32'h1, NONE);
    end
    bus(1'b1, 1'b0, 32'hffffffff, NONE);
    @(posedge pclk) rom_decode_en <= 1'b0;
    bus(1'b0, 1'b0, 32'hfff00000, NONE);
    @(posedge pclk) rom_decode_en <= 1'b1;
    rw(1'b1, sccsd_pkg::IDX_ROM_MASK, 32'h0000ff40);
    bus(1'b0, 1'b0, 32'hff400000, NONE);
  endtask
  task automatic t_io();
    logic [4:0] code [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f};
    logic [7:0] c0;
    c0 = a_cnt;
    rw(1'b1, sccsd_pkg::IDX_A_BASE, 32'h0300);
    foreach (code[i]) begin
      rw(1'b1, sccsd_pkg::IDX_A_CTRL, {24'h0, 3'b111, code[i]});
      bus(1'b1, 1'b1, 32'h0300 + code[i], SA);
      bus(1'b1, 1'b1, 32'h0301 + code[i], NONE);
      bus(1'b1, 1'b0, 32'h02ff, NONE);
    end
    rw(1'b1, sccsd_pkg::IDX_A_CTRL, 32'h000000e2);
    bus(1'b1, 1'b1, 32'h0300, NONE);
    rw(1'b1, sccsd_pkg::IDX_A_CTRL, 32'h000000c0);
    bus(1'b1, 1'b1, 32'h0300, SA);
    bus(1'b1, 1'b0, 32'h0300, NONE);
    rw(1'b1, sccsd_pkg::IDX_A_CTRL, 32'h000000a0);
    bus(1'b1, 1'b0, 32'h0300, SA);
    bus(1'b1, 1'b1, 32'h0300, NONE);
    bus(1'b0, 1'b0, 32'h0300, NONE);
    rw(1'b1, sccsd_pkg::IDX_A_CTRL, 32'h00000060);
    bus(1'b1, 1'b0, 32'h0300, NONE);
    rw(1'b1, sccsd_pkg::IDX_B_BASE, 32'h0310);
    rw(1'b1, sccsd_pkg::IDX_B_CTRL, 32'h000000e3);
    bus(1'b1, 1'b0, 32'h0313, SB);
    bus(1'b1, 1'b0, 32'h0314, NONE);
    rw(1'b0, sccsd_pkg::IDX_B_BASE, 32'h0);
    chk(rdat, 32'h0310);
    chk({24'h0, a_cnt - c0}, 32'h8);
    rw(1'b1, sccsd_pkg::IDX_B_CTRL, 32'h0);
  endtask
  task automatic t_fd();
    rw(1'b1, sccsd_pkg::IDX_FD_BASE, 32'h12340000);
    rw(1'b1, sccsd_pkg::IDX_FD_CTRL, 32'hffffffff);
    rw(1'b0, sccsd_pkg::IDX_FD_CTRL, 32'h0);
    chk(rdat, 32'h0707ffff);
    rw(1'b0, sccsd_pkg::IDX_FD_BASE, 32'h0);
    chk(rdat, 32'h12340000);
    bus(1'b0, 1'b0, 32'h12341fff, SF);
    bus(1'b0, 1'b1, 32'h12342000, NONE);
    bus(1'b0, 1'b0, 32'h92340000, NONE);
    bus(1'b1, 1'b0, 32'h12340000, NONE);
    rw(1'b1, sccsd_pkg::IDX_FD_CTRL, 32'h0607fffe);
    bus(1'b0, 1'b1, 32'h12342000, SF);
    bus(1'b0, 1'b0, 32'h12340000, NONE);
    rw(1'b1, sccsd_pkg::IDX_FD_CTRL, 32'h0507ffff);
    bus(1'b0, 1'b0, 32'h12340000, SF);
    bus(1'b0, 1'b1, 32'h12340000, NONE);
    rw(1'b1, sccsd_pkg::IDX_FD_CTRL, 32'h0307ffff);
    bus(1'b0, 1'b0, 32'h12340000, NONE);
    rw(1'b1, sccsd_pkg::IDX_FD_CTRL, 32'h07000000);
    bus(1'b0, 1'b1, 32'h5a5a0000, SF);
    // hold a hitting cycle across a status read: flash is bit 2 of the live selects
    @(posedge pclk) cyc_valid <= 1'b1;
    rw(1'b0, sccsd_pkg::IDX_STATUS, 32'h0);
    cyc_valid <= 1'b0;
    chk(rdat, 32'h00000004);
    chk({31'h0, rerr}, 32'h0);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rom();
    t_io();
    t_fd();
    end_of_test();
  end
  // far above the few hundred clocks the scenarios need
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_of_test();
  end
endmodule
